// file: common/sfrb_consts.svh
/*
 Offsets, field positions, reset values and counts of the bank 0 special
 register file. Assumes inclusion by its bare name from design files.
*/
`ifndef SFRB_CONSTS_SVH
`define SFRB_CONSTS_SVH
`define SFRB_OFS_INDIRECT_DATA_WINDOW 8'h00
`define SFRB_OFS_TIMER0_COUNT 8'h01
`define SFRB_OFS_PROG_COUNTER_LOW 8'h02
`define SFRB_OFS_CPU_STATUS_FLAGS 8'h03
`define SFRB_OFS_INDIRECT_ADDRESS_POINTER 8'h04
`define SFRB_OFS_PIN_BANK_A 8'h05
`define SFRB_OFS_PIN_BANK_B 8'h06
`define SFRB_OFS_CAPTURE_PIN_DATA_BITS 8'h07
`define SFRB_OFS_PC_UPPER_LATCH 8'h0a
`define SFRB_OFS_INTERRUPT_CONTROL 8'h0b
`define SFRB_OFS_PERIPHERAL_IRQ_FLAGS 8'h0c
`define SFRB_OFS_TIMER1_COUNT_LOW 8'h0e
`define SFRB_OFS_TIMER1_COUNT_HIGH 8'h0f
`define SFRB_OFS_TIMER1_CONTROL 8'h10
`define SFRB_OFS_TIMER2_COUNT 8'h11
`define SFRB_OFS_TIMER2_CONTROL 8'h12
`define SFRB_OFS_CCP_VALUE_LOW 8'h15
`define SFRB_OFS_CCP_VALUE_HIGH 8'h16
`define SFRB_OFS_CCP_CONTROL 8'h17
`define SFRB_OFS_ADC_RESULT 8'h1e
`define SFRB_OFS_ADC_CONTROL_MAIN 8'h1f
`define SFRB_OFS_PORT_DIRECTION_A 8'h20
`define SFRB_OFS_PORT_DIRECTION_B 8'h21
`define SFRB_OFS_RESET_CAUSE 8'h22
`define SFRB_OFS_DATA_RAM_BASE 8'h40
`define SFRB_BANK_BIT 7
`define SFRB_MASK_PIN_BANK_A 8'h1f
`define SFRB_MASK_CAPTURE_PIN 8'h05
`define SFRB_MASK_PC_UPPER 8'h1f
`define SFRB_MASK_STATUS_WRITE 8'he7
`define SFRB_MASK_TIMER1_CONTROL 8'h3f
`define SFRB_MASK_TIMER2_CONTROL 8'h7f
`define SFRB_MASK_CCP_CONTROL 8'h3f
`define SFRB_MASK_PIR 8'h47
`define SFRB_MASK_ADC_CONTROL 8'hfd
`define SFRB_MASK_INTERRUPT_CONTROL_KEEP 8'h01
`define SFRB_STATUS_POR 8'h18
`define SFRB_STATUS_KEEP_MASK 8'h07
`define SFRB_RAM_DEPTH 64
`define SFRB_RAM_AW 6
`endif

// file: common/sfrb_pkg.sv
/*
 Types of the bank 0 special register file.
 Assumes the constants header is compiled alongside.
*/
package sfrb_pkg;
  typedef enum logic [1:0] {SFRB_IDLE, SFRB_WAIT, SFRB_DONE} sfrb_phase_t;
  typedef enum logic [1:0] {SFRB_RST_NONE, SFRB_RST_PIN, SFRB_RST_WDT} sfrb_rst_kind_t;
  typedef struct packed {
    sfrb_phase_t phase;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] timer0_count;
    logic [7:0] prog_counter_low;
    logic [4:0] pc_upper;
    logic [12:0] pc;
    logic [7:0] cpu_status_flags;
    logic [7:0] indirect_address_pointer;
    logic [7:0] pin_latch_a;
    logic [7:0] pin_latch_b;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] capture_pin_data_bits;
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_irq_flags;
    logic [7:0] timer1_count_low;
    logic [7:0] timer1_count_high;
    logic [7:0] timer1_control;
    logic [7:0] timer2_count;
    logic [7:0] timer2_control;
    logic [7:0] ccp_value_low;
    logic [7:0] ccp_value_high;
    logic [7:0] ccp_control;
    logic [7:0] adc_control_main;
    logic [1:0] reset_cause;
    logic warm_pending;
  } sfrb_state_t;
endpackage

// file: src/sfrb_data_ram.sv
/*
 Small data memory reached through the indirect window or directly.
 Assumes one clock; read data come from a register one edge after the request.
*/
`timescale 1ns/1ps
`include "sfrb_consts.svh"
module sfrb_data_ram
(
  input wire logic pclk,
  input wire logic we,
  input wire logic [`SFRB_RAM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:`SFRB_RAM_DEPTH-1];

  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// file: src/sfrb_bank0.sv
/*
 Bank 0 special register file with an APB slave port, pin banks and a
 small data memory reached by the indirect window.
 Assumes pins are synchronous to pclk and warm resets arrive as pulses.
*/
// Design decision made here: register access over APB.
//
// Notes on behaviour
// - Shared core registers decode identically in either data bank.
// - Upper program counter latch is a writable 5-bit buffer.
// - Program counter bits 12..8 load only from the upper latch.
// - Every reset kind makes all pins of both banks inputs.
// - Reset values of the port registers apply to output latches.
// - Unimplemented bits and bank 0 addresses read zero; writes ignored; unshared bank 1 addresses hit data word 0x3f.
// - Pin and watchdog resets use the warm column, many fields kept.
`timescale 1ns/1ps
`include "sfrb_consts.svh"
module sfrb_bank0
  import sfrb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic pc_load_upper,
  output logic [12:0] prog_counter,
  input wire logic [7:0] pin_bank_a_in,
  output logic [7:0] pin_bank_a_out,
  output logic [7:0] pin_bank_a_oe,
  input wire logic [7:0] pin_bank_b_in,
  output logic [7:0] pin_bank_b_out,
  output logic [7:0] pin_bank_b_oe,
  input wire logic [7:0] capture_pin_in,
  input wire logic [7:0] adc_result_in
);
  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  // Bank bit folded away so shared registers answer at both mirrors.
  function automatic logic [7:0] file_addr(input logic [31:0] a);
    file_addr = {1'b0, a[8:2]};
  endfunction

  function automatic logic is_shared(input logic [7:0] f);
    is_shared = (f == `SFRB_OFS_INDIRECT_DATA_WINDOW) || (f == `SFRB_OFS_PROG_COUNTER_LOW) ||
      (f == `SFRB_OFS_CPU_STATUS_FLAGS) || (f == `SFRB_OFS_INDIRECT_ADDRESS_POINTER) ||
      (f == `SFRB_OFS_PC_UPPER_LATCH) || (f == `SFRB_OFS_INTERRUPT_CONTROL);
  endfunction

  function automatic logic is_ram(input logic [7:0] f);
    is_ram = f >= `SFRB_OFS_DATA_RAM_BASE;
  endfunction

  sfrb_state_t st;
  sfrb_state_t next_st;
  logic [7:0] ram_rdata;
  logic ram_we;
  logic [`SFRB_RAM_AW-1:0] ram_addr;
  logic [7:0] wbyte;
  logic [7:0] fa;
  logic [7:0] ra;
  logic bank1;
  logic warm;

  // ==========================================================================
  // Address and data memory
  // ==========================================================================
  always_comb
  begin
    wbyte = pwdata[7:0];
    bank1 = paddr[`SFRB_BANK_BIT + 2];
    fa = file_addr(paddr);
    // Shared registers resolve in either bank; others only in bank 0.
    if (bank1 && !is_shared(fa))
    begin
      fa = 8'hff;
    end
    // Window redirects to the memory word the pointer names.
    if (fa == `SFRB_OFS_INDIRECT_DATA_WINDOW)
    begin
      ra = {1'b0, st.indirect_address_pointer[6:0]};
    end
    else
    begin
      ra = fa;
    end
    ram_addr = ra[`SFRB_RAM_AW-1:0];
    ram_we = psel && penable && pwrite && (st.phase == SFRB_DONE) && is_ram(ra) && pstrb[0];
    warm = !external_reset_pin_n || watchdog_reset;
  end

  sfrb_data_ram u_ram
  (
    .pclk(pclk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(wbyte),
    .rdata(ram_rdata)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.warm_pending = warm;
    // The cause is caught while the request is seen: a one-cycle pulse has
    // already gone by the time the pending flag acts.
    if (warm)
    begin
      next_st.reset_cause = watchdog_reset ? SFRB_RST_WDT : SFRB_RST_PIN;
    end
    // Warm reset: pins to inputs, warm column values, the rest untouched.
    if (st.warm_pending)
    begin
      next_st.dir_a = 8'h00;
      next_st.dir_b = 8'h00;
      next_st.prog_counter_low = 8'h00;
      next_st.pc = 13'h0000;
      next_st.pc_upper = 5'h00;
      next_st.cpu_status_flags = st.cpu_status_flags & `SFRB_STATUS_KEEP_MASK;
      next_st.interrupt_control = st.interrupt_control & `SFRB_MASK_INTERRUPT_CONTROL_KEEP;
      next_st.peripheral_irq_flags = 8'h00;
      next_st.timer2_count = 8'h00;
      next_st.timer2_control = 8'h00;
      next_st.ccp_control = 8'h00;
      next_st.adc_control_main = 8'h00;
      next_st.phase = SFRB_IDLE;
    end
    else
    begin
      if (pc_load_upper)
      begin
        next_st.pc = {st.pc_upper, st.prog_counter_low};
      end
      case (st.phase)
        SFRB_IDLE:
        begin
          if (psel && !penable)
          begin
            next_st.phase = SFRB_WAIT;
          end
        end
        SFRB_WAIT:
        begin
          // One cycle lets the memory register its read word.
          next_st.phase = SFRB_DONE;
          next_st.pready = 1'b1;
          next_st.prdata = 32'h0000_0000;
          if (is_ram(ra))
          begin
            next_st.prdata[7:0] = ram_rdata;
          end
          else if (fa == `SFRB_OFS_TIMER0_COUNT)
          begin
            next_st.prdata[7:0] = st.timer0_count;
          end
          else if (fa == `SFRB_OFS_PROG_COUNTER_LOW)
          begin
            next_st.prdata[7:0] = st.prog_counter_low;
          end
          else if (fa == `SFRB_OFS_CPU_STATUS_FLAGS)
          begin
            next_st.prdata[7:0] = st.cpu_status_flags;
          end
          else if (fa == `SFRB_OFS_INDIRECT_ADDRESS_POINTER)
          begin
            next_st.prdata[7:0] = st.indirect_address_pointer;
          end
          else if (fa == `SFRB_OFS_PIN_BANK_A)
          begin
            next_st.prdata[7:0] = pin_bank_a_in & `SFRB_MASK_PIN_BANK_A;
          end
          else if (fa == `SFRB_OFS_PIN_BANK_B)
          begin
            next_st.prdata[7:0] = pin_bank_b_in;
          end
          else if (fa == `SFRB_OFS_CAPTURE_PIN_DATA_BITS)
          begin
            next_st.prdata[7:0] = capture_pin_in & `SFRB_MASK_CAPTURE_PIN;
          end
          else if (fa == `SFRB_OFS_PC_UPPER_LATCH)
          begin
            next_st.prdata[7:0] = {3'h0, st.pc_upper};
          end
          else if (fa == `SFRB_OFS_INTERRUPT_CONTROL)
          begin
            next_st.prdata[7:0] = st.interrupt_control;
          end
          else if (fa == `SFRB_OFS_PERIPHERAL_IRQ_FLAGS)
          begin
            next_st.prdata[7:0] = st.peripheral_irq_flags;
          end
          else if (fa == `SFRB_OFS_TIMER1_COUNT_LOW)
          begin
            next_st.prdata[7:0] = st.timer1_count_low;
          end
          else if (fa == `SFRB_OFS_TIMER1_COUNT_HIGH)
          begin
            next_st.prdata[7:0] = st.timer1_count_high;
          end
          else if (fa == `SFRB_OFS_TIMER1_CONTROL)
          begin
            next_st.prdata[7:0] = st.timer1_control;
          end
          else if (fa == `SFRB_OFS_TIMER2_COUNT)
          begin
            next_st.prdata[7:0] = st.timer2_count;
          end
          else if (fa == `SFRB_OFS_TIMER2_CONTROL)
          begin
            next_st.prdata[7:0] = st.timer2_control;
          end
          else if (fa == `SFRB_OFS_CCP_VALUE_LOW)
          begin
            next_st.prdata[7:0] = st.ccp_value_low;
          end
          else if (fa == `SFRB_OFS_CCP_VALUE_HIGH)
          begin
            next_st.prdata[7:0] = st.ccp_value_high;
          end
          else if (fa == `SFRB_OFS_CCP_CONTROL)
          begin
            next_st.prdata[7:0] = st.ccp_control;
          end
          else if (fa == `SFRB_OFS_ADC_RESULT)
          begin
            next_st.prdata[7:0] = adc_result_in;
          end
          else if (fa == `SFRB_OFS_ADC_CONTROL_MAIN)
          begin
            next_st.prdata[7:0] = st.adc_control_main;
          end
          else if (fa == `SFRB_OFS_PORT_DIRECTION_A)
          begin
            next_st.prdata[7:0] = st.dir_a;
          end
          else if (fa == `SFRB_OFS_PORT_DIRECTION_B)
          begin
            next_st.prdata[7:0] = st.dir_b;
          end
          else if (fa == `SFRB_OFS_RESET_CAUSE)
          begin
            next_st.prdata[7:0] = {6'h00, st.reset_cause};
          end
          if (pwrite)
          begin
            next_st.prdata = 32'h0000_0000;
          end
        end
        SFRB_DONE:
        begin
          next_st.phase = SFRB_IDLE;
          // Writes to unmapped places fall through every branch untouched.
          if (pwrite && pstrb[0])
          begin
            if (fa == `SFRB_OFS_TIMER0_COUNT)
            begin
              next_st.timer0_count = wbyte;
            end
            else if (fa == `SFRB_OFS_PROG_COUNTER_LOW)
            begin
              next_st.prog_counter_low = wbyte;
              next_st.pc = {st.pc_upper, wbyte};
            end
            else if (fa == `SFRB_OFS_CPU_STATUS_FLAGS)
            begin
              // Time-out and power-down flags are not writable.
              next_st.cpu_status_flags = (wbyte & `SFRB_MASK_STATUS_WRITE) |
                (st.cpu_status_flags & ~`SFRB_MASK_STATUS_WRITE);
            end
            else if (fa == `SFRB_OFS_INDIRECT_ADDRESS_POINTER)
            begin
              next_st.indirect_address_pointer = wbyte;
            end
            else if (fa == `SFRB_OFS_PIN_BANK_A)
            begin
              next_st.pin_latch_a = wbyte & `SFRB_MASK_PIN_BANK_A;
            end
            else if (fa == `SFRB_OFS_PIN_BANK_B)
            begin
              next_st.pin_latch_b = wbyte;
            end
            else if (fa == `SFRB_OFS_CAPTURE_PIN_DATA_BITS)
            begin
              next_st.capture_pin_data_bits = wbyte & `SFRB_MASK_CAPTURE_PIN;
            end
            else if (fa == `SFRB_OFS_PC_UPPER_LATCH)
            begin
              next_st.pc_upper = wbyte[4:0];
            end
            else if (fa == `SFRB_OFS_INTERRUPT_CONTROL)
            begin
              next_st.interrupt_control = wbyte;
            end
            else if (fa == `SFRB_OFS_PERIPHERAL_IRQ_FLAGS)
            begin
              next_st.peripheral_irq_flags = wbyte & `SFRB_MASK_PIR;
            end
            else if (fa == `SFRB_OFS_TIMER1_COUNT_LOW)
            begin
              next_st.timer1_count_low = wbyte;
            end
            else if (fa == `SFRB_OFS_TIMER1_COUNT_HIGH)
            begin
              next_st.timer1_count_high = wbyte;
            end
            else if (fa == `SFRB_OFS_TIMER1_CONTROL)
            begin
              next_st.timer1_control = wbyte & `SFRB_MASK_TIMER1_CONTROL;
            end
            else if (fa == `SFRB_OFS_TIMER2_COUNT)
            begin
              next_st.timer2_count = wbyte;
            end
            else if (fa == `SFRB_OFS_TIMER2_CONTROL)
            begin
              next_st.timer2_control = wbyte & `SFRB_MASK_TIMER2_CONTROL;
            end
            else if (fa == `SFRB_OFS_CCP_VALUE_LOW)
            begin
              next_st.ccp_value_low = wbyte;
            end
            else if (fa == `SFRB_OFS_CCP_VALUE_HIGH)
            begin
              next_st.ccp_value_high = wbyte;
            end
            else if (fa == `SFRB_OFS_CCP_CONTROL)
            begin
              next_st.ccp_control = wbyte & `SFRB_MASK_CCP_CONTROL;
            end
            else if (fa == `SFRB_OFS_ADC_CONTROL_MAIN)
            begin
              next_st.adc_control_main = wbyte & `SFRB_MASK_ADC_CONTROL;
            end
            else if (fa == `SFRB_OFS_PORT_DIRECTION_A)
            begin
              next_st.dir_a = wbyte & `SFRB_MASK_PIN_BANK_A;
            end
            else if (fa == `SFRB_OFS_PORT_DIRECTION_B)
            begin
              next_st.dir_b = wbyte;
            end
          end
        end
        default:
        begin
          next_st.phase = SFRB_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Power-on reset takes the first column; the port latches keep no value
  // worth keeping, so zero stands for unknown there.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.cpu_status_flags <= `SFRB_STATUS_POR;
      st.dir_a <= 8'h00;
      st.dir_b <= 8'h00;
      st.pin_latch_a <= 8'h00;
      st.pin_latch_b <= 8'h00;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    pready = st.pready;
    prdata = st.prdata;
    pslverr = st.pslverr;
    prog_counter = st.pc;
    pin_bank_a_out = st.pin_latch_a;
    pin_bank_b_out = st.pin_latch_b;
    pin_bank_a_oe = st.dir_a;
    pin_bank_b_oe = st.dir_b;
  end
endmodule

// file: tb/sfrb_bank0_asserts.sv
/*
 Checker of the bank 0 register file; it sees only the top module's ports.
 Assumes one clock and pins held steady by the bench while they are read.
*/
`timescale 1ns/1ps
module sfrb_bank0_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic pc_load_upper,
  input wire logic [12:0] prog_counter,
  input wire logic [7:0] pin_bank_b_in,
  input wire logic [7:0] pin_bank_a_oe,
  input wire logic [7:0] pin_bank_b_oe
);
  // ==========================================================
  // Helpers
  logic warm;
  assign warm = !external_reset_pin_n || watchdog_reset;
  // A low-byte counter write moves the upper latch into the counter as well.
  logic pcl_write;
  assign pcl_write = pready && pwrite && (paddr[8:0] == 9'h008);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Properties
  answer_delay_a: assert property ((psel && !penable) |-> ##2 pready)
    else $error("bus answer not two edges after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  unmapped_zero_a: assert property ((pready && !pwrite && paddr == 32'h20) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  pin_read_a: assert property ((pready && !pwrite && paddr == 32'h18) |-> prdata[7:0] == pin_bank_b_in)
    else $error("port read does not show pin levels");
  no_error_a: assert property (pready |-> !pslverr)
    else $error("error response raised");
  write_quiet_a: assert property ((pready && pwrite) |-> prdata == 32'h0)
    else $error("read data not zero on write");
  warm_input_a: assert property (warm |-> ##2 (pin_bank_a_oe == 8'h0 && pin_bank_b_oe == 8'h0))
    else $error("pins still driven after warm reset");
  por_input_a: assert property ($rose(presetn) |-> (pin_bank_a_oe == 8'h0 && pin_bank_b_oe == 8'h0))
    else $error("pins driven after power-on reset");
  pc_upper_only_a: assert property ($changed(prog_counter[12:8]) |->
    ($past(pc_load_upper) || $past(warm, 2) || $past(pcl_write)))
    else $error("upper program counter changed without a load");
endmodule

bind sfrb_bank0 sfrb_bank0_chk i_sfrb_bank0_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
  .prdata, .pslverr, .external_reset_pin_n, .watchdog_reset, .pc_load_upper, .prog_counter, .pin_bank_b_in,
  .pin_bank_a_oe, .pin_bank_b_oe);

// file: tb/sfrb_cpu_bus_model.sv
/*
 Model of the core's data bus as an APB master with one transfer task.
 Assumes the caller does not start a transfer while a warm reset is asserted.
*/
`timescale 1ns/1ps
module sfrb_cpu_bus_model
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
    output logic [31:0] r, output logic ok);
    int n;
    logic [7:0] v;
    v = d;
    if (a[8:0] == 9'h00c)
      v = v & 8'h3f;
    if (a[8:0] == 9'h014)
      v = v & 8'h1f;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    pstrb <= 4'h1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    r = prdata;
    ok = (pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse so stale values cannot pass as held.
    paddr <= ~a;
    pwdata <= ~pwdata;
  endtask
endmodule

// file: tb/tb_top.sv
/*
 Self-checking bench of the bank 0 register file.
 Assumes the bus model above and the byte address of a register at four times its offset.
*/
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic external_reset_pin_n, watchdog_reset, pc_load_upper;
  logic [12:0] prog_counter;
  logic [7:0] pin_bank_a_in, pin_bank_a_out, pin_bank_a_oe, pin_bank_b_in, pin_bank_b_out, pin_bank_b_oe;
  logic [7:0] capture_pin_in, adc_result_in;
  int err_count, n_tests;
  localparam logic [15:0] por_t [11] = '{16'h0800, 16'h0c18, 16'h1000, 16'h2800, 16'h3000, 16'h4000,
    16'h4400, 16'h4800, 16'h5c00, 16'h7c00, 16'h0000};
  localparam logic [23:0] msk_t [12] = '{24'h28ff1f, 24'h40ff3f, 24'h48ff7f, 24'h5cff3f, 24'h30ff47,
    24'h7cfffd, 24'h44a5a5, 24'h2cffff, 24'h78005a, 24'h1c0005, 24'h20ff00, 24'h14ff0a};
  localparam logic [15:0] wdt_t [11] = '{16'h0c07, 16'h2c01, 16'h3000, 16'h403f, 16'h4400, 16'h4800,
    16'h5c00, 16'h7c00, 16'h0800, 16'h2800, 16'h1046};

  sfrb_bank0 i_sfrb_bank0 (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .external_reset_pin_n, .watchdog_reset, .pc_load_upper, .prog_counter, .pin_bank_a_in,
    .pin_bank_a_out, .pin_bank_a_oe, .pin_bank_b_in, .pin_bank_b_out, .pin_bank_b_oe, .capture_pin_in,
    .adc_result_in);
  sfrb_cpu_bus_model i_sfrb_cpu_bus_model (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb);

  initial
  begin
    pclk = 1'b0;
    forever
      #5 pclk = ~pclk;
  end

  // ==========================================================
  // Tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [31:0] r);
    logic ok;
    i_sfrb_cpu_bus_model.xfer(w, a, d, r, ok);
    if (ok !== 1'b1)
    begin
      $display("[ERR] answer at %h expected 1 seen 0", a);
      err_count++;
      final_report();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk($sformatf("read %h", a), {24'h0, e}, r);
  endtask

  // Bus traffic is paused here because transfers are dropped during a warm reset.
  task automatic warm(input logic pin);
    if (pin)
      external_reset_pin_n <= 1'b0;
    else
      watchdog_reset <= 1'b1;
    @(posedge pclk);
    external_reset_pin_n <= 1'b1;
    watchdog_reset <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    presetn = 1'b0;
    external_reset_pin_n = 1'b1;
    watchdog_reset = 1'b0;
    pc_load_upper = 1'b0;
    pin_bank_a_in = 8'hea;
    pin_bank_b_in = 8'h96;
    capture_pin_in = 8'hff;
    adc_result_in = 8'h5a;
    err_count = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (por_t[i])
      rc({24'h0, por_t[i][15:8]}, por_t[i][7:0]);
    chk("drive b", 32'h0, {24'h0, pin_bank_b_oe});
    chk("latch b", 32'h0, {24'h0, pin_bank_b_out});
    rc(32'h18, 8'h96);
    $display("test power-on done");
    foreach (msk_t[i])
    begin
      wr({24'h0, msk_t[i][23:16]}, msk_t[i][15:8]);
      rc({24'h0, msk_t[i][23:16]}, msk_t[i][7:0]);
    end
    chk("latch a", 32'h1f, {24'h0, pin_bank_a_out});
    $display("test masks done");
    wr(32'h210, 8'h45);
    rc(32'h010, 8'h45);
    wr(32'h228, 8'h12);
    rc(32'h028, 8'h12);
    rc(32'h208, 8'h00);
    rc(32'h218, 8'h00);
    $display("test mirror done");
    wr(32'h000, 8'hc3);
    rc(32'h000, 8'hc3);
    rc(32'h114, 8'hc3);
    wr(32'h118, 8'h3c);
    wr(32'h010, 8'h46);
    rc(32'h000, 8'h3c);
    $display("test indirect done");
    wr(32'h008, 8'h34);
    @(posedge pclk);
    chk("pc after low write", 32'h1234, {19'h0, prog_counter});
    wr(32'h028, 8'h0a);
    @(posedge pclk);
    chk("pc before load", 32'h1234, {19'h0, prog_counter});
    pc_load_upper <= 1'b1;
    @(posedge pclk);
    pc_load_upper <= 1'b0;
    @(posedge pclk);
    chk("pc after load", 32'h0a34, {19'h0, prog_counter});
    $display("test pc load done");
    wr(32'h18, 8'h3c);
    wr(32'h84, 8'h55);
    wr(32'h0c, 8'hff);
    rc(32'h0c, 8'h3f);
    rc(32'h18, 8'h96);
    chk("latch b", 32'h3c, {24'h0, pin_bank_b_out});
    chk("drive b on", 32'h1, {31'h0, pin_bank_b_oe != 8'h00});
    warm(1'b0);
    chk("drive b", 32'h0, {24'h0, pin_bank_b_oe});
    chk("latch b kept", 32'h3c, {24'h0, pin_bank_b_out});
    chk("pc cleared", 32'h0, {19'h0, prog_counter});
    foreach (wdt_t[i])
      rc({24'h0, wdt_t[i][15:8]}, wdt_t[i][7:0]);
    rc(32'h88, 8'h02);
    rc(32'h114, 8'hc3);
    $display("test watchdog done");
    wr(32'h84, 8'h55);
    wr(32'h80, 8'h0f);
    warm(1'b1);
    chk("drive a", 32'h0, {24'h0, pin_bank_a_oe});
    chk("drive b", 32'h0, {24'h0, pin_bank_b_oe});
    rc(32'h88, 8'h01);
    $display("test pin reset done");
    final_report();
  end
endmodule
